// ==== qrs_pkg.sv ====
// shared constants and types for the dual-port burst sram link
package qrs_pkg;
	localparam int DATA_W       = 18;
	localparam int ADDR_W       = 4;
	localparam int MEM_DEPTH    = 16;
	localparam int FIFO_DEPTH   = 8;
	localparam int FIFO_W       = ADDR_W + 2 * DATA_W;
	localparam int SLOTS        = 4;
	// latency in link half-cycles from read address capture to word0
	localparam int LAT_PLL_HALF = 3;
	localparam int LAT_BYP_HALF = 2;
	localparam int SYS_PERIOD_NS = 50;
	localparam int K_PERIOD_NS   = 400;
	localparam int K_PERIOD_CYC  = K_PERIOD_NS / SYS_PERIOD_NS;
	localparam logic [2:0] PH_RESET     = 3'h0;
	localparam logic [2:0] PH_K_FALL    = 3'(K_PERIOD_CYC / 2);
	localparam logic [2:0] PH_RD_LAUNCH = 3'h6;
	localparam logic [2:0] PH_WR_LAUNCH = 3'h2;
	localparam logic       SEL_IDLE     = 1'b1;
	localparam logic [DATA_W-1:0] DATA_RST = '0;
	localparam logic [ADDR_W-1:0] ADDR_RST = '0;
	typedef enum logic {
		CAP_WORD0 = 1'b0,
		CAP_WORD1 = 1'b1
	} cap_t;
endpackage

// ==== qrs_if.sv ====
// link wires between the sram device end and its controller
`timescale 1ns/1ps
interface qrs_if;
	import qrs_pkg::*;
	logic              k;
	logic              k_n;
	logic              c;
	logic              c_n;
	logic              read_port_select_n;
	logic              write_port_select_n;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] d;
	logic              pll_bypass;
	logic [DATA_W-1:0] q;
	logic              q_valid;
	logic              echo_strobe;
	logic              echo_strobe_n;
	modport device (
		input  k, k_n, c, c_n, read_port_select_n, write_port_select_n, addr, d, pll_bypass,
		output q, q_valid, echo_strobe, echo_strobe_n
	);
	modport ctrl (
		output k, k_n, c, c_n, read_port_select_n, write_port_select_n, addr, d, pll_bypass,
		input  q, q_valid, echo_strobe, echo_strobe_n
	);
endinterface

// ==== qrs_fifo.sv ====
// parameterised valid/ready fifo with registered flags
`timescale 1ns/1ps
module qrs_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input  wire logic             i_sys_clk,
	input  wire logic             i_sys_rst,
	input  wire logic             i_in_valid,
	input  wire logic [WIDTH-1:0] i_in_data,
	output logic                  o_in_ready,
	output logic                  o_out_valid,
	output logic [WIDTH-1:0]      o_out_data,
	input  wire logic             i_out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_reg, wp_next, rp_reg, rp_next;
	logic [AW:0]      cnt_reg, cnt_next;
	logic             push, pop;

	assign push = i_in_valid && o_in_ready;
	assign pop  = o_out_valid && i_out_ready;
	assign o_out_data = mem[rp_reg];

	always_comb begin
		wp_next  = push ? AW'(wp_reg + 1'b1) : wp_reg;
		rp_next  = pop ? AW'(rp_reg + 1'b1) : rp_reg;
		cnt_next = (AW+1)'(cnt_reg + push - pop);
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wp_reg      <= '0;
			rp_reg      <= '0;
			cnt_reg     <= '0;
			o_in_ready  <= 1'b1;
			o_out_valid <= 1'b0;
		end else begin
			wp_reg      <= wp_next;
			rp_reg      <= rp_next;
			cnt_reg     <= cnt_next;
			o_in_ready  <= cnt_next != (AW+1)'(DEPTH);
			o_out_valid <= cnt_next != '0;
		end
	end

	always_ff @(posedge i_sys_clk) begin
		if (push) begin
			mem[wp_reg] <= i_in_data;
		end
	end
endmodule

// ==== qrs_ctrl.sv ====
// controller end: makes the link clocks, drives address slots, collects reads
`timescale 1ns/1ps
module qrs_ctrl
	import qrs_pkg::*;
(
	input  wire logic              i_sys_clk,
	input  wire logic              i_sys_rst,
	qrs_if.ctrl                    link,
	input  wire logic              i_pll_bypass,
	input  wire logic              i_rd_req,
	input  wire logic [ADDR_W-1:0] i_rd_addr,
	output logic                   o_rd_accept,
	input  wire logic              i_wr_valid,
	input  wire logic [FIFO_W-1:0] i_wr_data,
	output logic                   o_wr_ready,
	output logic                   o_rd_valid,
	output logic [DATA_W-1:0]      o_rd_data0,
	output logic [DATA_W-1:0]      o_rd_data1
);
	// ************************************************
	// clock divider and address/data slots
	// ************************************************
	logic [2:0]        phase_reg, phase_next;
	logic              k_next, rsel_reg, rsel_next, wsel_reg, wsel_next;
	logic [ADDR_W-1:0] addr_reg, addr_next, wa_reg, wa_next;
	logic [DATA_W-1:0] d_reg, d_next, w1_reg, w1_next;
	logic              acc_next, wr_take, f_valid, f_ready;
	logic [FIFO_W-1:0] f_data;

	qrs_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.i_sys_clk  (i_sys_clk),
		.i_sys_rst  (i_sys_rst),
		.i_in_valid (i_wr_valid),
		.i_in_data  (i_wr_data),
		.o_in_ready (o_wr_ready),
		.o_out_valid(f_valid),
		.o_out_data (f_data),
		.i_out_ready(f_ready)
	);

	always_comb begin
		phase_next = 3'(phase_reg + 1'b1);
		k_next     = phase_next < PH_K_FALL;
		rsel_next  = rsel_reg;
		wsel_next  = wsel_reg;
		addr_next  = addr_reg;
		d_next     = d_reg;
		wa_next    = wa_reg;
		w1_next    = w1_reg;
		acc_next   = 1'b0;
		wr_take    = 1'b0;
		if (phase_next == PH_RD_LAUNCH) begin
			// read address slot, ahead of the rising edge of k
			acc_next  = i_rd_req;
			wr_take   = f_valid;
			rsel_next = ~i_rd_req;
			wsel_next = ~f_valid;
			addr_next = i_rd_addr;
			d_next    = f_data[DATA_W-1:0];
			wa_next   = f_data[FIFO_W-1 -: ADDR_W];
			w1_next   = f_data[2*DATA_W-1 -: DATA_W];
		end else if (phase_next == PH_WR_LAUNCH) begin
			// write address slot, ahead of the rising edge of k_n
			rsel_next = SEL_IDLE;
			wsel_next = SEL_IDLE;
			addr_next = wa_reg;
			d_next    = w1_reg;
		end
	end
	assign f_ready = wr_take;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			phase_reg                <= PH_RESET;
			rsel_reg                 <= SEL_IDLE;
			wsel_reg                 <= SEL_IDLE;
			addr_reg                 <= ADDR_RST;
			d_reg                    <= DATA_RST;
			wa_reg                   <= ADDR_RST;
			w1_reg                   <= DATA_RST;
			o_rd_accept              <= 1'b0;
			link.k                   <= 1'b1;
			link.k_n                 <= 1'b0;
			link.c                   <= 1'b1;
			link.c_n                 <= 1'b0;
			link.read_port_select_n  <= SEL_IDLE;
			link.write_port_select_n <= SEL_IDLE;
			link.addr                <= ADDR_RST;
			link.d                   <= DATA_RST;
			link.pll_bypass          <= 1'b0;
		end else begin
			phase_reg                <= phase_next;
			rsel_reg                 <= rsel_next;
			wsel_reg                 <= wsel_next;
			addr_reg                 <= addr_next;
			d_reg                    <= d_next;
			wa_reg                   <= wa_next;
			w1_reg                   <= w1_next;
			o_rd_accept              <= acc_next;
			link.k                   <= k_next;
			link.k_n                 <= ~k_next;
			// output clocks follow k so launch and capture edges coincide
			link.c                   <= k_next;
			link.c_n                 <= ~k_next;
			link.read_port_select_n  <= rsel_next;
			link.write_port_select_n <= wsel_next;
			link.addr                <= addr_next;
			link.d                   <= d_next;
			link.pll_bypass          <= i_pll_bypass;
		end
	end

	// ************************************************
	// read capture against the echo strobes
	// ************************************************
	logic [DATA_W+2:0] s1_reg, s2_reg;
	logic              e3_reg, en3_reg, edge_hit, vld_next;
	cap_t              cap_reg, cap_next;
	logic [DATA_W-1:0] r0_reg, r0_next, o0_next, o1_next;

	always_comb begin
		edge_hit = (s2_reg[1] & ~e3_reg) | (s2_reg[0] & ~en3_reg);
		cap_next = cap_reg;
		r0_next  = r0_reg;
		o0_next  = o_rd_data0;
		o1_next  = o_rd_data1;
		vld_next = 1'b0;
		if (edge_hit) begin
			if (!s2_reg[2]) begin
				cap_next = CAP_WORD0;
			end else if (cap_reg == CAP_WORD0) begin
				r0_next  = s2_reg[DATA_W+2:3];
				cap_next = CAP_WORD1;
			end else begin
				o0_next  = r0_reg;
				o1_next  = s2_reg[DATA_W+2:3];
				vld_next = 1'b1;
				cap_next = CAP_WORD0;
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s1_reg     <= '0;
			s2_reg     <= '0;
			e3_reg     <= 1'b0;
			en3_reg    <= 1'b0;
			cap_reg    <= CAP_WORD0;
			r0_reg     <= DATA_RST;
			o_rd_data0 <= DATA_RST;
			o_rd_data1 <= DATA_RST;
			o_rd_valid <= 1'b0;
		end else begin
			s1_reg     <= {link.q, link.q_valid, link.echo_strobe, link.echo_strobe_n};
			s2_reg     <= s1_reg;
			e3_reg     <= s2_reg[1];
			en3_reg    <= s2_reg[0];
			cap_reg    <= cap_next;
			r0_reg     <= r0_next;
			o_rd_data0 <= o0_next;
			o_rd_data1 <= o1_next;
			o_rd_valid <= vld_next;
		end
	end
endmodule

// ==== qrs_device.sv ====
// device end: two-word burst sram with split read and write data ports
`timescale 1ns/1ps
module qrs_device
	import qrs_pkg::*;
(
	input  wire logic i_sys_clk,
	input  wire logic i_sys_rst,
	qrs_if.device     link,
	input  wire logic i_single_clock,
	output logic      o_write_done
);
	// ************************************************
	// pin synchronisers and edge detection
	// ************************************************
	localparam int SW = 7 + ADDR_W + DATA_W;
	localparam logic [SW-1:0] SYNC_IDLE = {1'b1, 1'b0, 1'b1, 1'b0, SEL_IDLE, SEL_IDLE, 1'b0,
		ADDR_RST, DATA_RST};
	logic [SW-1:0]     s1_reg, s2_reg;
	logic [3:0]        clk3_reg;
	logic              k2, kn2, c2, cn2, rps2, wps2, pll2;
	logic [ADDR_W-1:0] addr2;
	logic [DATA_W-1:0] d2;
	logic              k_rise, kn_rise, k_edge, out_edge;

	assign {k2, kn2, c2, cn2, rps2, wps2, pll2, addr2, d2} = s2_reg;

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			// start at the pins' reset levels so release shows no false clock edge
			s1_reg   <= SYNC_IDLE;
			s2_reg   <= SYNC_IDLE;
			clk3_reg <= SYNC_IDLE[SW-1 -: 4];
		end else begin
			s1_reg   <= {link.k, link.k_n, link.c, link.c_n, link.read_port_select_n,
				link.write_port_select_n, link.pll_bypass, link.addr, link.d};
			s2_reg   <= s1_reg;
			clk3_reg <= {k2, kn2, c2, cn2};
		end
	end

	always_comb begin
		k_rise   = k2 & ~clk3_reg[3];
		kn_rise  = kn2 & ~clk3_reg[2];
		k_edge   = k_rise | kn_rise;
		// single clock mode lets k and k_n launch the read port
		out_edge = i_single_clock ? k_edge
			: ((c2 & ~clk3_reg[1]) | (cn2 & ~clk3_reg[0]));
	end

	// ************************************************
	// write capture and self-timed commit
	// ************************************************
	logic [DATA_W-1:0] mem0 [MEM_DEPTH];
	logic [DATA_W-1:0] mem1 [MEM_DEPTH];
	logic              wpend_reg, wpend_next, commit_reg, commit_next;
	logic [DATA_W-1:0] w0_reg, w0_next, w1_reg, w1_next;
	logic [ADDR_W-1:0] wa_reg, wa_next;

	always_comb begin
		wpend_next  = wpend_reg;
		commit_next = 1'b0;
		w0_next     = w0_reg;
		w1_next     = w1_reg;
		wa_next     = wa_reg;
		if (k_rise && !wps2) begin
			wpend_next = 1'b1;
			w0_next    = d2;
		end else if (kn_rise && wpend_reg) begin
			wpend_next  = 1'b0;
			wa_next     = addr2;
			w1_next     = d2;
			commit_next = 1'b1;
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			wpend_reg    <= 1'b0;
			commit_reg   <= 1'b0;
			w0_reg       <= DATA_RST;
			w1_reg       <= DATA_RST;
			wa_reg       <= ADDR_RST;
			o_write_done <= 1'b0;
		end else begin
			wpend_reg    <= wpend_next;
			commit_reg   <= commit_next;
			w0_reg       <= w0_next;
			w1_reg       <= w1_next;
			wa_reg       <= wa_next;
			o_write_done <= commit_reg;
		end
	end

	// the array itself carries no reset, contents are undefined at start
	always_ff @(posedge i_sys_clk) begin
		if (commit_reg) begin
			mem0[wa_reg] <= w0_reg;
			mem1[wa_reg] <= w1_reg;
		end
	end

	// ************************************************
	// read lookup and latency pipeline
	// ************************************************
	logic [DATA_W-1:0] rd0, rd1;
	logic              rd_go, fwd;
	logic [DATA_W-1:0] sd_reg [SLOTS];
	logic [DATA_W-1:0] sd_next [SLOTS];
	logic [SLOTS-1:0]  sv_reg, sv_next;

	always_comb begin
		rd_go = k_rise && !rps2;
		// a commit still in flight is forwarded; a read in the write's own slot still sees the old words
		fwd   = commit_reg && (wa_reg == addr2);
		rd0   = fwd ? w0_reg : mem0[addr2];
		rd1   = fwd ? w1_reg : mem1[addr2];
	end

	// slot j leaves on the (j+1)th link half-cycle; assumes c edges track k edges
	always_comb begin
		for (int i = 0; i < SLOTS; i++) begin
			sd_next[i] = sd_reg[i];
			sv_next[i] = sv_reg[i];
		end
		if (k_edge) begin
			for (int i = 0; i < SLOTS - 1; i++) begin
				sd_next[i] = sd_reg[i+1];
				sv_next[i] = sv_reg[i+1];
			end
			sd_next[SLOTS-1] = DATA_RST;
			sv_next[SLOTS-1] = 1'b0;
			if (rd_go && pll2) begin
				sd_next[LAT_PLL_HALF-1] = rd0;
				sd_next[LAT_PLL_HALF]   = rd1;
				sv_next[LAT_PLL_HALF-1] = 1'b1;
				sv_next[LAT_PLL_HALF]   = 1'b1;
			end else if (rd_go) begin
				sd_next[LAT_BYP_HALF-1] = rd0;
				sd_next[LAT_BYP_HALF]   = rd1;
				sv_next[LAT_BYP_HALF-1] = 1'b1;
				sv_next[LAT_BYP_HALF]   = 1'b1;
			end
		end
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			for (int i = 0; i < SLOTS; i++) begin
				sd_reg[i] <= DATA_RST;
			end
			sv_reg <= '0;
		end else begin
			for (int i = 0; i < SLOTS; i++) begin
				sd_reg[i] <= sd_next[i];
			end
			sv_reg <= sv_next;
		end
	end

	// ************************************************
	// output registers and echo strobes
	// ************************************************
	logic [DATA_W-1:0] q_next;
	logic              qv_next, echo_next, echo_n_next;

	always_comb begin
		q_next      = link.q;
		qv_next     = link.q_valid;
		if (out_edge) begin
			q_next  = sd_reg[0];
			qv_next = sv_reg[0];
		end
		// strobes run whenever the launching clock runs, read or not
		echo_next   = i_single_clock ? k2 : c2;
		echo_n_next = i_single_clock ? kn2 : cn2;
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			link.q             <= DATA_RST;
			link.q_valid       <= 1'b0;
			link.echo_strobe   <= 1'b0;
			link.echo_strobe_n <= 1'b0;
		end else begin
			link.q             <= q_next;
			link.q_valid       <= qv_next;
			link.echo_strobe   <= echo_next;
			link.echo_strobe_n <= echo_n_next;
		end
	end
endmodule

// ==== qrs_link_props.sv ====
// concurrent checks on the wires between controller and device ends
`timescale 1ns/1ps
module qrs_link_props
	import qrs_pkg::*;
(
	input wire logic              i_sys_clk,
	input wire logic              i_sys_rst,
	input wire logic              k,
	input wire logic              k_n,
	input wire logic              c,
	input wire logic              c_n,
	input wire logic              read_port_select_n,
	input wire logic              write_port_select_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] d,
	input wire logic              pll_bypass,
	input wire logic [DATA_W-1:0] q,
	input wire logic              q_valid,
	input wire logic              echo_strobe,
	input wire logic              echo_strobe_n
);
	logic [2:0] settle_reg;
	logic [2:0] settle_next;

	// ****************
	// settle counter
	// ****************
	// echo pipeline still holds reset values for a few cycles after release
	always_comb begin
		settle_next = (settle_reg == 3'h7) ? settle_reg : settle_reg + 3'h1;
	end

	always_ff @(posedge i_sys_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			settle_reg <= 3'h0;
		end else begin
			settle_reg <= settle_next;
		end
	end

	// ****************
	// assertions
	// ****************
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_sys_rst);

	a_clock_pairs: assert property (k_n == !k && c == k && c_n == k_n)
		else $error("link clock pair mismatch");
	a_k_period: assert property ($rose(k) |-> k[*4] ##1 !k[*4] ##1 k)
		else $error("input clock period wrong");
	a_rsel_slot: assert property ($fell(read_port_select_n) |=>
		(!read_port_select_n && $stable(addr))[*3] ##1 read_port_select_n)
		else $error("read select or read address slot wrong");
	a_rsel_krise: assert property ($fell(read_port_select_n) |-> ##2 $rose(k))
		else $error("read address not on input clock rise");
	a_wsel_slot: assert property ($fell(write_port_select_n) |=>
		(!write_port_select_n && $stable(d))[*3] ##1 write_port_select_n ##2 $rose(k_n))
		else $error("write select or write slot wrong");
	a_q_pair: assert property ($rose(q_valid) |-> q_valid[*8])
		else $error("read burst shorter than two words");
	a_q_hold: assert property ($rose(q_valid) |=> $stable(q)[*3])
		else $error("read word not held a half cycle");
	a_lat_pll: assert property ($fell(read_port_select_n) && pll_bypass |-> ##[15:20] q_valid)
		else $error("read latency with pll active wrong");
	a_lat_bypass: assert property ($fell(read_port_select_n) && !pll_bypass |-> ##[10:14] q_valid)
		else $error("read latency with pll bypassed wrong");
	a_echo_follow: assert property (settle_reg == 3'h7 |->
		echo_strobe == $past(c, 3) && echo_strobe_n == $past(c_n, 3))
		else $error("echo strobes do not follow output clocks");

	c_read_pll: cover property ($rose(q_valid) && pll_bypass);
	c_read_bypass: cover property ($rose(q_valid) && !pll_bypass);
	c_concurrent: cover property (!read_port_select_n && !write_port_select_n);
endmodule

// ==== quad_rate_sram_port_interface_tb.sv ====
// self-checking bench: controller and device ends joined across the link
`timescale 1ns/1ps
module quad_rate_sram_port_interface_tb;
	import qrs_pkg::*;
	logic              i_sys_clk    = 1'b0;
	logic              i_sys_rst    = 1'b1;
	logic              pll_bypass   = 1'b1;
	logic              single_clock = 1'b0;
	logic              rd_req       = 1'b0;
	logic [ADDR_W-1:0] rd_addr      = '0;
	logic              wr_valid     = 1'b0;
	logic [FIFO_W-1:0] wr_data      = '0;
	logic              rd_accept;
	logic              wr_ready;
	logic              rd_valid;
	logic              write_done;
	logic              refused      = 1'b0;
	logic [DATA_W-1:0] rd_data0;
	logic [DATA_W-1:0] rd_data1;
	logic [DATA_W-1:0] mem0 [MEM_DEPTH];
	logic [DATA_W-1:0] mem1 [MEM_DEPTH];
	int                err_count    = 0;
	int                comparisons  = 0;
	int                done_cnt     = 0;
	int                pushed       = 0;

	always #(SYS_PERIOD_NS / 2) i_sys_clk = ~i_sys_clk;

	qrs_if qrs_if_i ();
	qrs_ctrl qrs_ctrl_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst), .link(qrs_if_i.ctrl),
		.i_pll_bypass(pll_bypass), .i_rd_req(rd_req), .i_rd_addr(rd_addr),
		.o_rd_accept(rd_accept), .i_wr_valid(wr_valid), .i_wr_data(wr_data),
		.o_wr_ready(wr_ready), .o_rd_valid(rd_valid), .o_rd_data0(rd_data0),
		.o_rd_data1(rd_data1));
	qrs_device qrs_device_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
		.link(qrs_if_i.device), .i_single_clock(single_clock), .o_write_done(write_done));
	qrs_link_props qrs_link_props_i (.i_sys_clk(i_sys_clk), .i_sys_rst(i_sys_rst),
		.k(qrs_if_i.k), .k_n(qrs_if_i.k_n), .c(qrs_if_i.c), .c_n(qrs_if_i.c_n),
		.read_port_select_n(qrs_if_i.read_port_select_n),
		.write_port_select_n(qrs_if_i.write_port_select_n), .addr(qrs_if_i.addr),
		.d(qrs_if_i.d), .pll_bypass(qrs_if_i.pll_bypass), .q(qrs_if_i.q),
		.q_valid(qrs_if_i.q_valid), .echo_strobe(qrs_if_i.echo_strobe),
		.echo_strobe_n(qrs_if_i.echo_strobe_n));

	// ****************
	// helpers
	// ****************
	always @(posedge i_sys_clk) begin
		if (write_done === 1'b1) done_cnt++;
		if (wr_valid && wr_ready === 1'b0) refused = 1'b1;
	end

	function automatic logic [DATA_W-1:0] exp_word(input logic [ADDR_W-1:0] a, input logic hi);
		return hi ? mem1[a] : mem0[a];
	endfunction

	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp,
			input string what);
		comparisons++;
		if (seen !== exp) begin
			err_count++;
			$display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// valid stays up between back-to-back pushes; wr_end lowers it
	task automatic wr(input logic [ADDR_W-1:0] a);
		mem0[a] = DATA_W'($urandom);
		mem1[a] = DATA_W'($urandom);
		wr_valid <= 1'b1;
		wr_data  <= {a, mem1[a], mem0[a]};
		for (int n = 0; n < 200; n++) begin
			@(negedge i_sys_clk);
			if (wr_ready === 1'b1) break;
		end
		@(posedge i_sys_clk);
		pushed++;
	endtask

	task automatic wr_end();
		wr_valid <= 1'b0;
	endtask

	task automatic rd(input logic [ADDR_W-1:0] a);
		rd_req  <= 1'b1;
		rd_addr <= a;
		for (int n = 0; n < 40; n++) begin
			@(negedge i_sys_clk);
			if (rd_accept === 1'b1) break;
		end
		check(DATA_W'(rd_accept), DATA_W'(1'b1), "read accept");
		@(posedge i_sys_clk);
		rd_req <= 1'b0;
		for (int n = 0; n < 60; n++) begin
			@(negedge i_sys_clk);
			if (rd_valid === 1'b1) break;
		end
		check(DATA_W'(rd_valid), DATA_W'(1'b1), "read result");
		check(rd_data0, exp_word(a, 1'b0), "first word");
		check(rd_data1, exp_word(a, 1'b1), "second word");
		@(posedge i_sys_clk);
	endtask

	task automatic wait_drain();
		for (int n = 0; n < 2000; n++) begin
			@(negedge i_sys_clk);
			if (done_cnt == pushed) break;
		end
		check(DATA_W'(done_cnt), DATA_W'(pushed), "writes completed");
		@(posedge i_sys_clk);
	endtask

	// ****************
	// tests
	// ****************
	initial begin
		repeat (30000) @(posedge i_sys_clk);
		err_count++;
		$display("[FAIL] %0t watchdog expired", $time);
		summarize();
	end

	initial begin
		void'($urandom(76));
		repeat (2) @(posedge i_sys_clk);
		i_sys_rst <= 1'b0;
		@(negedge i_sys_clk);
		check(DATA_W'(wr_ready), DATA_W'(1'b1), "ready after reset");
		check(DATA_W'(qrs_if_i.read_port_select_n), DATA_W'(SEL_IDLE), "read idle");
		check(DATA_W'(qrs_if_i.write_port_select_n), DATA_W'(SEL_IDLE), "write idle");
		@(posedge i_sys_clk);
		// sixteen pushes overrun the eight-deep buffer while the link drains slowly
		for (int a = 0; a < MEM_DEPTH; a++) wr(ADDR_W'(a));
		wr_end();
		wait_drain();
		check(DATA_W'(refused), DATA_W'(1'b1), "buffer refused when full");
		for (int a = 0; a < MEM_DEPTH; a++) rd(ADDR_W'(a));
		$display("test fill and readback done");
		for (int m = 0; m < 4; m++) begin
			pll_bypass   <= m[0];
			single_clock <= m[1];
			repeat (16) @(posedge i_sys_clk);
			// writes to the upper half while the lower half is read
			fork
				begin
					for (int i = 0; i < 4; i++) wr(ADDR_W'($urandom_range(15, 8)));
					wr_end();
				end
				for (int i = 0; i < 4; i++) rd(ADDR_W'($urandom_range(7, 0)));
			join
			wait_drain();
			for (int i = 0; i < 3; i++) rd(ADDR_W'($urandom_range(15, 8)));
			$display("test mode %0d done", m);
		end
		// read taken while the same address is still being written
		wr(ADDR_W'(5));
		wr_end();
		// a read in the same slot precedes the write address, so issue it one slot later
		for (int n = 0; n < 40 && qrs_if_i.write_port_select_n !== 1'b0; n++) begin
			@(negedge i_sys_clk);
		end
		@(posedge i_sys_clk);
		rd(ADDR_W'(5));
		wait_drain();
		rd(ADDR_W'(5));
		$display("test coherency done");
		summarize();
	end
endmodule
